// file: rtl/cpim_pkg.sv
// shared constants and types of the command pulse and input mapper
package cpim_pkg;
  // ----------------------------------------------------------------
  // register map, byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SEL_BASE_OFS = 8'h00; // ten selects, one word each
  localparam logic [7:0] CTRL_OFS     = 8'h28;
  localparam logic [7:0] STATUS_OFS   = 8'h2C;
  localparam logic [7:0] COUNT_OFS    = 8'h30;
  localparam logic [7:0] FUNC_OFS     = 8'h34;
  localparam int         N_INPUTS     = 10;
  localparam int         N_FUNC       = 32;
  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam int CTRL_FMT_POS  = 0; // 2 bits
  localparam int CTRL_FAST_POS = 2;
  localparam int CTRL_GRP_POS  = 3; // 2 bits
  localparam int CTRL_EN_POS   = 5;
  localparam int STAT_ERR_POS  = 0;
  localparam int STAT_OVR_POS  = 1;
  localparam int SEL_NC_POS    = 7; // inside each byte
  localparam logic [6:0] FN_NONE    = 7'h00;
  localparam logic [6:0] FN_DEV_CLR = 7'h07;
  localparam logic [6:0] FN_INHIBIT = 7'h08;
  localparam int CLR_INPUT = 6; // seventh input
  localparam int INH_INPUT = 9; // tenth input
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [9:0][31:0] SEL_RESET = {
    32'h00000E88, 32'h00050505, 32'h00040404, 32'h00000F07, 32'h00030303,
    32'h0000100C, 32'h00060606, 32'h0091910A, 32'h00818181, 32'h00828282};
  localparam logic [5:0] CTRL_RESET = 6'h20;
  // ----------------------------------------------------------------
  // timing: least pulse period per input path
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 10;
  localparam int FAST_QUAD_NS   = 125;
  localparam int FAST_PULSE_NS  = 250;
  localparam int GEN_PULSE_NS   = 5000;
  localparam int FQ_RAW = FAST_QUAD_NS * CLK_MHZ / 1000;
  localparam int FP_RAW = FAST_PULSE_NS * CLK_MHZ / 1000;
  localparam int GP_RAW = GEN_PULSE_NS * CLK_MHZ / 1000;
  localparam int FAST_QUAD_CYC  = (FQ_RAW < 1) ? 1 : FQ_RAW;
  localparam int FAST_PULSE_CYC = (FP_RAW < 1) ? 1 : FP_RAW;
  localparam int GEN_PULSE_CYC  = (GP_RAW < 1) ? 1 : GP_RAW;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FMT_QUAD_A = 2'b00, FMT_DIR2 = 2'b01, FMT_QUAD_B = 2'b10, FMT_SIGN = 2'b11
  } cpim_fmt_type;
  typedef enum logic [1:0] {
    GRP_POS = 2'b00, GRP_VEL = 2'b01, GRP_TRQ = 2'b10, GRP_TRQ_ALT = 2'b11
  } cpim_grp_type;
endpackage

// file: rtl/cpim_pulse_decoder.sv
// edge decoder for command pulse trains in three formats
`timescale 1ns/1ps
module cpim_pulse_decoder #(
  parameter int GAP_W = 6
) (
  input  wire logic              pclk,     // system clock
  input  wire logic              presetn,  // async reset, low
  input  wire logic              pulse_a,  // pulse / phase a
  input  wire logic              pulse_b,  // sign / phase b
  input  wire logic [1:0]        fmt,      // pulse format
  input  wire logic [GAP_W-1:0]  min_gap,  // least cycles between counts
  output logic                   up,       // one count forward
  output logic                   dn,       // one count backward
  output logic                   too_fast  // rate exceeded
);
  typedef struct packed {
    logic             pa;
    logic             pb;
    logic [GAP_W-1:0] gap;
    logic             up;
    logic             dn;
    logic             fast;
  } cpim_dec_type;
  cpim_dec_type st_reg, st_next;
  logic ca, cb, ev;

  // ----------------------------------------------------------------
  // edge classification
  // ----------------------------------------------------------------
  // quadrature counts every edge; other formats only rising edges
  always_comb begin
    st_next = st_reg;
    ca = pulse_a != st_reg.pa;
    cb = pulse_b != st_reg.pb;
    st_next.pa = pulse_a;
    st_next.pb = pulse_b;
    st_next.up = 1'b0;
    st_next.dn = 1'b0;
    st_next.fast = 1'b0;
    unique case (cpim_pkg::cpim_fmt_type'(fmt))
      cpim_pkg::FMT_QUAD_A, cpim_pkg::FMT_QUAD_B: begin
        // both phases moving at once means an edge was missed
        if (ca && cb) begin
          st_next.fast = 1'b1;
        end else if (ca) begin
          st_next.up = pulse_a != pulse_b;
          st_next.dn = pulse_a == pulse_b;
        end else if (cb) begin
          st_next.up = pulse_a == pulse_b;
          st_next.dn = pulse_a != pulse_b;
        end
      end
      cpim_pkg::FMT_DIR2: begin
        if (ca && pulse_a && cb && pulse_b) begin
          st_next.fast = 1'b1;
        end else begin
          st_next.up = ca && pulse_a;
          st_next.dn = cb && pulse_b;
        end
      end
      cpim_pkg::FMT_SIGN: begin
        st_next.up = ca && pulse_a && !pulse_b;
        st_next.dn = ca && pulse_a && pulse_b;
      end
    endcase
    ev = st_next.up || st_next.dn;
    // spacing check against the path's top rate
    if (ev) begin
      st_next.gap = '0;
      if (st_reg.gap < min_gap) begin
        st_next.fast = 1'b1;
      end
    end else if (st_reg.gap != '1) begin
      st_next.gap = st_reg.gap + 1'b1;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '{pa: 1'b0, pb: 1'b0, gap: '1, up: 1'b0, dn: 1'b0, fast: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign up = st_reg.up;
  assign dn = st_reg.dn;
  assign too_fast = st_reg.fast;
endmodule

// file: rtl/cpim_input_mapper.sv
// maps ten control inputs to function codes with per-input polarity
`timescale 1ns/1ps
module cpim_input_mapper #(
  parameter int N_IN = 10
) (
  input  wire logic [N_IN-1:0][31:0] sel,      // function selects
  input  wire logic [1:0]            grp,      // control mode group
  input  wire logic [N_IN-1:0]       pin_in,   // high: tied to common
  output logic [31:0]                func,     // active functions by code
  output logic                       map_err   // illegal placement
);
  logic [N_IN-1:0][6:0] code;
  logic [N_IN-1:0]      act;

  // ----------------------------------------------------------------
  // per input decode
  // ----------------------------------------------------------------
  for (genvar i = 0; i < N_IN; i++) begin : g_in
    logic [7:0] b;
    // group 3 is read as torque so no code is undefined
    assign b = (grp == 2'b00) ? sel[i][7:0] :
               (grp == 2'b01) ? sel[i][15:8] : sel[i][23:16];
    assign code[i] = b[6:0];
    // open: active when tied; closed: active when loose
    assign act[i] = (code[i] != cpim_pkg::FN_NONE) &&
                    (b[cpim_pkg::SEL_NC_POS] ? !pin_in[i] : pin_in[i]);
  end

  // any input may carry any function; codes above 31 drive nothing here
  always_comb begin
    func = '0;
    map_err = 1'b0;
    for (int i = 0; i < N_IN; i++) begin
      if (act[i] && code[i] < 7'd32) begin
        func[code[i][4:0]] = 1'b1;
      end
      if (code[i] == cpim_pkg::FN_DEV_CLR && i != cpim_pkg::CLR_INPUT) begin
        map_err = 1'b1;
      end
      if (code[i] == cpim_pkg::FN_INHIBIT && i != cpim_pkg::INH_INPUT) begin
        map_err = 1'b1;
      end
    end
  end
endmodule

// file: rtl/cpim_top.sv
// command pulse capture and control input mapper with apb registers
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
// Contract
// - pulse+sign and two-train formats count on each rising pulse edge
// - quadrature counts every edge of both phases
// - fast port quadrature counts four per phase cycle
// - rate limits 8M quad, 4M other fast, 200k general; host obeys
// - any function may be routed to any control input
// - each input's polarity is chosen on its own
// - normally open: active when tied to common
// - normally closed: active when loose from common
// - input n takes its function from select register n
// - code zero leaves the input without function in that group
// - deviation clear only on input seven, else error
// - inhibit blocks command pulses, allowed only on input ten
module cpim_top #(
  parameter int GAP_W = 6
) (
  input  wire logic        pclk,       // 10 mhz clock
  input  wire logic        presetn,    // async reset, low
  input  wire logic        psel,       // apb select
  input  wire logic        penable,    // apb access phase
  input  wire logic        pwrite,     // apb direction
  input  wire logic [7:0]  paddr,      // apb byte address
  input  wire logic [31:0] pwdata,     // apb write data
  input  wire logic [3:0]  pstrb,      // apb byte strobes
  output logic [31:0]      prdata,     // apb read data
  output logic             pready,     // apb ready
  output logic             pslverr,    // apb error
  input  wire logic        fast_a,     // fast_diff_pulse_port pulse
  input  wire logic        fast_b,     // fast_diff_pulse_port sign
  input  wire logic        gen_a,      // general_pulse_port pulse
  input  wire logic        gen_b,      // general_pulse_port sign
  input  wire logic [9:0]  ctrl_in,    // control inputs, high tied
  output logic [31:0]      func_active,// functions now on
  output logic             cmd_up,     // forward count pulse
  output logic             cmd_dn,     // reverse count pulse
  output logic             cfg_error,  // misplaced function
  output logic [31:0]      position_count // accumulated command
);
  typedef struct packed {
    logic [9:0][31:0] sel;
    logic [1:0]       fmt;
    logic             fast;
    logic [1:0]       grp;
    logic             en;
    logic             ovr;
    logic             err;
    logic [31:0]      count;
    logic [31:0]      func;
    logic             up;
    logic             dn;
    logic [31:0]      rdata;
  } cpim_top_type;
  cpim_top_type st_reg, st_next;

  logic             pa, pb, d_up, d_dn, d_fast, m_err, setup, acc, wr;
  logic [31:0]      m_func, ctrl_w, stat_w;
  logic [5:0]       idx;
  logic             mapped, inh;
  logic [GAP_W-1:0] min_gap;

  // merges a write under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sb);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < 4; k++) begin
      if (sb[k]) begin
        r[8*k +: 8] = nw[8*k +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // pulse path
  // ----------------------------------------------------------------
  // port select picks pins; rate check follows the chosen path
  always_comb begin
    pa = st_reg.fast ? fast_a : gen_a;
    pb = st_reg.fast ? fast_b : gen_b;
    if (!st_reg.fast) begin
      min_gap = GAP_W'(cpim_pkg::GEN_PULSE_CYC);
    end else if (st_reg.fmt[0] == 1'b0) begin
      min_gap = GAP_W'(cpim_pkg::FAST_QUAD_CYC);
    end else begin
      min_gap = GAP_W'(cpim_pkg::FAST_PULSE_CYC);
    end
  end

  cpim_pulse_decoder #(.GAP_W(GAP_W)) u_dec (
    .pclk     (pclk),
    .presetn  (presetn),
    .pulse_a  (pa),
    .pulse_b  (pb),
    .fmt      (st_reg.fmt),
    .min_gap  (min_gap),
    .up       (d_up),
    .dn       (d_dn),
    .too_fast (d_fast)
  );

  cpim_input_mapper #(.N_IN(cpim_pkg::N_INPUTS)) u_map (
    .sel     (st_reg.sel),
    .grp     (st_reg.grp),
    .pin_in  (ctrl_in),
    .func    (m_func),
    .map_err (m_err)
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // zero wait: read data is latched in the setup cycle
  assign setup = psel && !penable;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign idx = paddr[7:2];
  assign mapped = (paddr[1:0] == 2'b00) && (idx <= 6'(cpim_pkg::FUNC_OFS >> 2));
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign inh = st_reg.func[cpim_pkg::FN_INHIBIT[4:0]];
  assign ctrl_w = {26'h0, st_reg.en, st_reg.grp, st_reg.fast, st_reg.fmt};
  assign stat_w = {30'h0, st_reg.ovr, st_reg.err};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // functions seen one cycle after the pins
    st_next.func = m_func;
    st_next.err = m_err;
    // inhibit swallows pulses before they reach the count
    st_next.up = d_up && st_reg.en && !inh;
    st_next.dn = d_dn && st_reg.en && !inh;
    st_next.count = 32'(st_reg.count + {31'h0, st_next.up} - {31'h0, st_next.dn});
    // overrun clears by writing one; a new overrun wins
    if (wr && paddr == cpim_pkg::STATUS_OFS && pstrb[0] && pwdata[cpim_pkg::STAT_OVR_POS]) begin
      st_next.ovr = 1'b0;
    end
    if (d_fast) begin
      st_next.ovr = 1'b1;
    end
    if (wr && mapped) begin
      if (idx < 6'(cpim_pkg::N_INPUTS)) begin
        st_next.sel[idx[3:0]] = merge(st_reg.sel[idx[3:0]], pwdata, pstrb);
      end else if (paddr == cpim_pkg::CTRL_OFS && pstrb[0]) begin
        st_next.fmt = pwdata[cpim_pkg::CTRL_FMT_POS +: 2];
        st_next.fast = pwdata[cpim_pkg::CTRL_FAST_POS];
        st_next.grp = pwdata[cpim_pkg::CTRL_GRP_POS +: 2];
        st_next.en = pwdata[cpim_pkg::CTRL_EN_POS];
      end else if (paddr == cpim_pkg::COUNT_OFS) begin
        // software load beats a pulse landing in the same cycle
        st_next.count = merge(st_reg.count, pwdata, pstrb);
      end
    end
    if (setup) begin
      if (idx < 6'(cpim_pkg::N_INPUTS) && paddr[1:0] == 2'b00) begin
        st_next.rdata = st_reg.sel[idx[3:0]];
      end else if (paddr == cpim_pkg::CTRL_OFS) begin
        st_next.rdata = ctrl_w;
      end else if (paddr == cpim_pkg::STATUS_OFS) begin
        st_next.rdata = stat_w;
      end else if (paddr == cpim_pkg::COUNT_OFS) begin
        st_next.rdata = st_reg.count;
      end else if (paddr == cpim_pkg::FUNC_OFS) begin
        st_next.rdata = st_reg.func;
      end else begin
        st_next.rdata = 32'h00000000;
      end
    end
  end

  // state register; position bytes of inputs one, two and ten default to the safe closed polarities
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.sel <= cpim_pkg::SEL_RESET;
      st_reg.fmt <= cpim_pkg::CTRL_RESET[1:0];
      st_reg.fast <= cpim_pkg::CTRL_RESET[2];
      st_reg.grp <= cpim_pkg::CTRL_RESET[4:3];
      st_reg.en <= cpim_pkg::CTRL_RESET[5];
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = st_reg.rdata;
  assign func_active = st_reg.func;
  assign cmd_up = st_reg.up;
  assign cmd_dn = st_reg.dn;
  assign cfg_error = st_reg.err;
  assign position_count = st_reg.count;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb_clk @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic cnt_wr;
  assign cnt_wr = wr && paddr == cpim_pkg::COUNT_OFS;

  sign_rise_a: assert property (
    (st_reg.fmt == 2'b11 && !st_reg.fast && $rose(gen_a) && !gen_b && st_reg.en
     && !inh && !$stable(st_reg.fmt) == 1'b0) |-> ##2 (cmd_up && !cmd_dn))
    else $error("rising pulse with sign low not counted forward");

  quad_edge_a: assert property (
    (st_reg.fmt[0] == 1'b0 && $changed(pa) && $stable(pb) && $stable(st_reg.fast)
     && st_reg.en && !inh && $stable(st_reg.fmt)) |-> ##2 ((cmd_up || cmd_dn)
     && ($past(cnt_wr) || position_count != $past(position_count))))
    else $error("quadrature edge not counted");

  rate_flag_a: assert property (
    (!st_reg.fast && d_up && $past(d_up, 2)) |=> st_reg.ovr)
    else $error("general port pulses too close not flagged");

  closed_pol_a: assert property (
    (st_reg.grp == 2'b00 && st_reg.sel[0][7:0] == 8'h82 && !ctrl_in[0]) |=> func_active[2])
    else $error("closed input loose but function off");

  open_pol_a: assert property (
    (st_reg.grp == 2'b00 && st_reg.sel[5][7:0] == 8'h03 && !ctrl_in[5]
     && st_reg.sel[0][6:0] != 7'h03) |=> !func_active[3])
    else $error("open input loose but function on");

  sel_write_a: assert property (
    (wr && paddr == cpim_pkg::SEL_BASE_OFS && pstrb == 4'hF) |=> st_reg.sel[0] == $past(pwdata))
    else $error("select write not stored");

  clr_place_a: assert property (
    (st_reg.grp == 2'b00 && st_reg.sel[0][6:0] == cpim_pkg::FN_DEV_CLR) |=> cfg_error)
    else $error("clear function off input seven not flagged");

  inhibit_hold_a: assert property (
    (inh && !cnt_wr) |=> $stable(position_count))
    else $error("count moved while inhibited");

  quad_cov: cover property (st_reg.fmt == 2'b00 && cmd_dn);
  inh_cov: cover property (inh && (d_up || d_dn));
  ovr_cov: cover property ($rose(st_reg.ovr));
endmodule

// file: verif/cpim_host_model.sv
// host controller model: command pulse trains and control contacts
`timescale 1ns/1ps
module cpim_host_model (
  input  wire logic pclk,    // system clock
  output logic      fast_a,  // fast port pulse or phase a
  output logic      fast_b,  // fast port sign or phase b
  output logic      gen_a,   // general port pulse or phase a
  output logic      gen_b,   // general port sign or phase b
  output logic [9:0] ctrl_in // contacts, high tied to common
);
  // ----------------------------------------------------------------
  // idle levels
  // ----------------------------------------------------------------
  // closed-contact travel inhibits and pulse inhibit sit tied when released
  initial begin
    fast_a = 1'b0;
    fast_b = 1'b0;
    gen_a = 1'b0;
    gen_b = 1'b0;
    ctrl_in = 10'h203;
  end
  // put a level pair on one port and hold it; hold sets the pulse rate
  task automatic drive(input logic fast, input logic a, input logic b, input int hold);
    @(posedge pclk);
    if (fast) begin
      fast_a <= a;
      fast_b <= b;
    end else begin
      gen_a <= a;
      gen_b <= b;
    end
    repeat (hold) @(posedge pclk);
  endtask
  // one pulse on phase a with sign b, or one pulse on line b
  task automatic pulse(input logic fast, input logic sign, input logic on_b, input int hold);
    if (on_b) begin
      drive(fast, 1'b0, 1'b1, hold);
      drive(fast, 1'b0, 1'b0, hold);
    end else begin
      drive(fast, 1'b0, sign, hold);
      drive(fast, 1'b1, sign, hold);
      drive(fast, 1'b0, sign, hold);
    end
  endtask
  // one full phase cycle, four edges, a leading b when forward
  task automatic quad(input logic fast, input logic fwd, input int hold);
    drive(fast, fwd, !fwd, hold);
    drive(fast, 1'b1, 1'b1, hold);
    drive(fast, !fwd, fwd, hold);
    drive(fast, 1'b0, 1'b0, hold);
  endtask
  task automatic set_inputs(input logic [9:0] v);
    @(posedge pclk);
    ctrl_in <= v;
  endtask
endmodule

// file: verif/tb.sv
// self-checking bench for the command pulse and input mapper
`timescale 1ns/1ps
module tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        fast_a;
  logic        fast_b;
  logic        gen_a;
  logic        gen_b;
  logic [9:0]  ctrl_in;
  logic [31:0] func_active;
  logic        cmd_up;
  logic        cmd_dn;
  int          n_up;
  int          n_dn;
  logic        cfg_error;
  logic [31:0] position_count;
  logic [31:0] q;
  logic        e;
  int          errors;
  int          n_tests;
  localparam logic [9:0][31:0] SEL_EXP = {
    32'h00000E88, 32'h00050505, 32'h00040404, 32'h00000F07, 32'h00030303,
    32'h0000100C, 32'h00060606, 32'h0091910A, 32'h00818181, 32'h00828282};
  cpim_top #(.GAP_W(6)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .fast_a, .fast_b, .gen_a, .gen_b, .ctrl_in, .func_active,
    .cmd_up, .cmd_dn, .cfg_error, .position_count);
  cpim_host_model host (.pclk, .fast_a, .fast_b, .gen_a, .gen_b, .ctrl_in);
  // count the one-cycle step pulses while they stand
  always @(posedge pclk) begin
    if (cmd_up === 1'b1) n_up++;
    if (cmd_dn === 1'b1) n_dn++;
  end
  // ----------------------------------------------------------------
  // compare and bus helpers
  // ----------------------------------------------------------------
  task automatic chk32(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic chk1(input string nm, input logic x, input logic g);
    chk32(nm, {31'h0, x}, {31'h0, g});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // request held until pready is seen high; no fixed latency assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees ready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 10; i++) begin
      rd(8'(4 * i));
      chk32("select reset", SEL_EXP[i], q);
    end
    rd(8'h38);
    chk1("unmapped error", 1'b1, e);
    chk32("unmapped data", 32'h0, q);
    $display("test reset done");
  endtask
  // pulse plus sign on the general port, gaps kept above the rate floor
  task automatic t_sign;
    wr(cpim_pkg::CTRL_OFS, 32'h00000023);
    wr(cpim_pkg::COUNT_OFS, 32'h0);
    for (int i = 0; i < 3; i++) host.pulse(1'b0, 1'b0, 1'b0, 60);
    for (int i = 0; i < 2; i++) host.pulse(1'b0, 1'b1, 1'b0, 60);
    cyc(5);
    chk32("sign count", 32'h1, position_count);
    rd(cpim_pkg::STATUS_OFS);
    chk1("overrun", 1'b0, q[cpim_pkg::STAT_OVR_POS]);
    $display("test sign done");
  endtask
  task automatic t_trains;
    wr(cpim_pkg::CTRL_OFS, 32'h00000021);
    wr(cpim_pkg::COUNT_OFS, 32'h0);
    n_up = 0;
    n_dn = 0;
    host.pulse(1'b0, 1'b0, 1'b0, 60);
    host.pulse(1'b0, 1'b0, 1'b1, 60);
    host.pulse(1'b0, 1'b0, 1'b0, 60);
    host.pulse(1'b0, 1'b0, 1'b0, 60);
    cyc(5);
    chk32("train count", 32'h2, position_count);
    chk32("up pulses", 32'h3, n_up);
    chk32("down pulses", 32'h1, n_dn);
    $display("test trains done");
  endtask
  // both quadrature codes; fast port steps at close spacing
  task automatic t_quad;
    wr(cpim_pkg::CTRL_OFS, 32'h00000024);
    wr(cpim_pkg::COUNT_OFS, 32'h0);
    host.quad(1'b1, 1'b1, 1);
    host.quad(1'b1, 1'b1, 1);
    cyc(5);
    chk32("quad fwd", 32'h8, position_count);
    host.quad(1'b1, 1'b0, 1);
    cyc(5);
    chk32("quad rev", 32'h4, position_count);
    wr(cpim_pkg::CTRL_OFS, 32'h00000022);
    host.quad(1'b0, 1'b1, 60);
    cyc(5);
    chk32("quad gen", 32'h8, position_count);
    // general port stepped every other cycle: still counted, overrun flagged
    host.quad(1'b0, 1'b1, 1);
    cyc(5);
    chk32("quad gen fast", 32'hC, position_count);
    rd(cpim_pkg::STATUS_OFS);
    chk1("overrun set", 1'b1, q[cpim_pkg::STAT_OVR_POS]);
    wr(cpim_pkg::STATUS_OFS, 32'h00000002);
    rd(cpim_pkg::STATUS_OFS);
    chk1("overrun cleared", 1'b0, q[cpim_pkg::STAT_OVR_POS]);
    $display("test quad done");
  endtask
  // inhibit on input ten is normally closed: an open contact blocks counts
  task automatic t_inhibit;
    wr(cpim_pkg::CTRL_OFS, 32'h00000024);
    wr(cpim_pkg::COUNT_OFS, 32'h0);
    host.set_inputs(10'h002);
    host.quad(1'b1, 1'b1, 2);
    cyc(5);
    chk32("inhibited", 32'h0, position_count);
    chk1("closed input one loose", 1'b1, func_active[2]);
    host.set_inputs(10'h203);
    host.quad(1'b1, 1'b1, 2);
    cyc(5);
    chk32("released", 32'h4, position_count);
    $display("test inhibit done");
  endtask
  task automatic t_misplace;
    wr(cpim_pkg::CTRL_OFS, 32'h00000020);
    wr(cpim_pkg::SEL_BASE_OFS, 32'h00000007);
    cyc(3);
    chk1("clear misplaced", 1'b1, cfg_error);
    wr(cpim_pkg::SEL_BASE_OFS, 32'h00000008);
    cyc(3);
    chk1("inhibit misplaced", 1'b1, cfg_error);
    wr(cpim_pkg::SEL_BASE_OFS, 32'h00828282);
    cyc(3);
    chk1("placement ok", 1'b0, cfg_error);
    $display("test misplace done");
  endtask
  // code 20 in position byte, code 21 in velocity byte of input one
  task automatic t_map;
    wr(cpim_pkg::SEL_BASE_OFS, 32'h00001514);
    cyc(3);
    chk1("open tied", 1'b1, func_active[20]);
    host.set_inputs(10'h202);
    cyc(3);
    chk1("open loose", 1'b0, func_active[20]);
    wr(cpim_pkg::SEL_BASE_OFS, 32'h00001594);
    cyc(3);
    chk1("closed loose", 1'b1, func_active[20]);
    chk1("neighbour", 1'b0, func_active[1]);
    host.set_inputs(10'h203);
    cyc(3);
    chk1("closed tied", 1'b0, func_active[20]);
    wr(cpim_pkg::CTRL_OFS, 32'h00000028);
    cyc(3);
    chk1("velocity byte", 1'b1, func_active[21]);
    chk1("position byte off", 1'b0, func_active[20]);
    wr(cpim_pkg::CTRL_OFS, 32'h00000020);
    wr(cpim_pkg::SEL_BASE_OFS, 32'h0);
    cyc(3);
    chk32("no function", 32'h0, func_active & 32'h00300000);
    wr(8'h24, 32'h00000014);
    cyc(3);
    chk1("routed to ten", 1'b1, func_active[20]);
    wr(8'h24, 32'h00000E88);
    wr(cpim_pkg::SEL_BASE_OFS, 32'h00828282);
    $display("test map done");
  endtask
  // ----------------------------------------------------------------
  // clock, reset, sequence, watchdog
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    errors = 0;
    n_tests = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
    cyc(10);
    presetn <= 1'b1;
    t_reset();
    t_sign();
    t_trains();
    t_quad();
    t_inhibit();
    t_misplace();
    t_map();
    test_done();
  end
  // whole run is a few thousand cycles; stop well past that
  initial begin
    #3000000;
    errors++;
    test_done();
  end
endmodule
